/* File: logic/tmr_oneshot.sv */
// Overview of operation
// - Trigger-pin valid edge clears and starts counter in external one-shot mode.
// - With compare_b below compare_a: active at compare_b, inactive at compare_a.
// - With compare_b above compare_a: roles swap; software never sets them equal.
// - Edge select field bits 4-5 picks rising, falling or both edges.
// - Counter starts at once when mode field is written non-stop.
// - Start is unsynchronised to count clock; first match may slip one count.
// - Compare contents after stop are not guaranteed; nothing relies on them.
// - Software one-shot mode still restarts on trigger pin valid edges.
// - Overflow flag sets on wrap from maximum to zero in counting modes.
// - Clearing overflow flag before count reaches one is overridden.
// - Capture beats a coinciding read; that read's data is undefined.
// - Stopped timer ignores both trigger/capture pins.
// - One-shot works only in free-running and clear-on-edge modes.
// - Pin used as count clock performs no captures.
// - Capture latches on count clock fall; match signal on next rise.
// - Pin high after reset gives rising edge on first enable only.
// - Edges need two equal samples; fast clock for counting, prescaler for capture.
// - Software one-shot trigger clears, starts and launches a pulse.
// - Counter keeps running after a pulse until stop is written.
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module tmr_oneshot
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Timer pins
  input wire logic trigger_input_pin,
  input wire logic second_capture_pin,
  output logic pulse_output_pin,
  // Match signals
  output logic match_a_interrupt,
  output logic match_b_interrupt
);

  // Valid edge decode: 00 falling, 01 rising, 11 both, 10 none
  function automatic logic valid_edge(input logic prev, input logic cur,
                                      input logic [1:0] sel);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    case (sel)
      2'h0: valid_edge = fall;
      2'h1: valid_edge = rise;
      2'h3: valid_edge = rise | fall;
      default: valid_edge = 1'b0;
    endcase
  endfunction

  // Two-sample filter step
  function automatic logic filt_step(input logic cur, input logic prev,
                                     input logic held);
    filt_step = (cur == prev) ? cur : held;
  endfunction

  // Register state
  tmr_mode_t mode;
  logic [2:0] ccc;
  logic [1:0] outc;
  logic [7:0] presc;
  logic [15:0] compare_a;
  logic [15:0] compare_b;
  logic [15:0] counter_value;
  logic overflow_flag;
  tmr_aph_t aph;
  logic aph_valid;

  // Bus decode
  wire logic bus_take = hsel & hready & htrans[1];
  wire logic wr_now = aph_valid & aph.wr;
  wire logic wr_mode = wr_now & (aph.addr == TMR_OFS_MODE);
  wire logic wr_ccc = wr_now & (aph.addr == TMR_OFS_CCC);
  wire logic wr_outc = wr_now & (aph.addr == TMR_OFS_OUTC);
  wire logic wr_presc = wr_now & (aph.addr == TMR_OFS_PRESC);
  wire logic wr_cmpa = wr_now & (aph.addr == TMR_OFS_CMPA);
  wire logic wr_cmpb = wr_now & (aph.addr == TMR_OFS_CMPB);
  wire tmr_mode_t wmode = tmr_mode_t'(hwdata[TMR_MODE_LO +: 2]);
  wire logic sw_trig = wr_outc & hwdata[TMR_OUTC_SWT];
  wire logic ovf_clr = wr_mode & ~hwdata[TMR_MODE_OVF];

  // Control decode
  wire logic running = (mode != TMR_STOP);
  wire tmr_cksel_t cksel = tmr_cksel_t'(presc[TMR_PRE_CLK +: 2]);
  wire logic [1:0] es_trig = presc[TMR_PRE_ES +: 2];
  wire logic [1:0] es_sec = presc[TMR_PRE_ES2 +: 2];
  wire logic pin_clk = (cksel == TMR_CK_PIN);
  // One-shot only in free-run and clear-on-edge modes
  wire logic os_mode = outc[1] & ((mode == TMR_FREE) | (mode == TMR_EDGE_CLR));

  // Pin synchronisers
  logic trig_s1;
  logic trig_s2;
  logic sec_s1;
  logic sec_s2;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      sec_s1 <= 1'b0;
      sec_s2 <= 1'b0;
    end else begin
      trig_s1 <= trigger_input_pin;
      trig_s2 <= trig_s1;
      sec_s1 <= second_capture_pin;
      sec_s2 <= sec_s1;
    end
  end

  // Prescaler runs free, so a start lands anywhere in a count period
  logic [3:0] div;
  wire logic [3:0] div_top = (cksel == TMR_CK_DIV4) ? TMR_DIV4 :
                             (cksel == TMR_CK_DIV16) ? TMR_DIV16 : TMR_DIV_ZERO;
  wire logic div_wrap = (div >= div_top);
  wire logic [3:0] div_half = {1'b0, div_top[3:1]};
  wire logic pre_rise = div_wrap;
  wire logic pre_fall = (div == div_half);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      div <= TMR_DIV_ZERO;
    else
      div <= div_wrap ? TMR_DIV_ZERO : div + 4'h1;
  end

  // Sample strobe: fast clock for pin counting, prescaler for capture
  wire logic samp = pin_clk ? 1'b1 : pre_rise;
  logic trig_prev;
  logic trig_filt;
  logic trig_filt_q;
  logic sec_prev;
  logic sec_filt;
  logic sec_filt_q;
  logic seen_run;
  // Filters wait for the first enable, then track the pins
  wire logic filt_on = running | seen_run;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_prev <= 1'b0;
      trig_filt <= 1'b0;
      trig_filt_q <= 1'b0;
      sec_prev <= 1'b0;
      sec_filt <= 1'b0;
      sec_filt_q <= 1'b0;
      seen_run <= 1'b0;
    end else begin
      seen_run <= seen_run | running;
      trig_filt_q <= trig_filt;
      sec_filt_q <= sec_filt;
      if (filt_on & samp) begin
        trig_prev <= trig_s2;
        trig_filt <= filt_step(trig_s2, trig_prev, trig_filt);
        sec_prev <= sec_s2;
        sec_filt <= filt_step(sec_s2, sec_prev, sec_filt);
      end
    end
  end

  wire logic trig_edge = running & valid_edge(trig_filt_q, trig_filt, es_trig);
  wire logic sec_edge = running & valid_edge(sec_filt_q, sec_filt, es_sec);
  // Count tick from prescaler or pin edge
  wire logic tick = running & (pin_clk ? trig_edge : pre_rise);
  // No capture from the pin that is the count clock
  wire logic cap_trig = trig_edge & ~pin_clk;
  // External trigger; honoured in software mode as well
  wire logic ext_trig = os_mode & cap_trig;
  wire logic os_start = os_mode & (sw_trig | ext_trig);
  wire logic edge_clr = (mode == TMR_EDGE_CLR) & cap_trig;

  // Match detection at count clock rise
  wire logic hit_a = tick & (counter_value == compare_a);
  wire logic hit_b = tick & (counter_value == compare_b);
  wire logic wrap = tick & (counter_value == TMR_CNT_MAX);
  wire logic match_clr = (mode == TMR_MATCH_CLR) & hit_a;

  // Counter runs as soon as mode is non-stop
  // Keeps running after a pulse until stopped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      counter_value <= TMR_CNT_ZERO;
    else if (!running)
      counter_value <= TMR_CNT_ZERO;
    else if (os_start | edge_clr | match_clr)
      counter_value <= TMR_CNT_ZERO;
    else if (tick)
      counter_value <= counter_value + TMR_CNT_ONE;
  end

  // Overflow on wrap; re-set while count still zero after wrap
  logic wrap_pend;
  wire logic ovf_set = wrap | (wrap_pend & ovf_clr);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wrap_pend <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      wrap_pend <= wrap | (wrap_pend & ~tick & running);
      overflow_flag <= ovf_set | (overflow_flag & ~ovf_clr);
    end
  end

  // Capture requests latched, taken on count clock fall
  logic cap_a_req;
  logic cap_b_req;
  logic [15:0] cap_a_val;
  logic [15:0] cap_b_val;
  wire logic b_edge = ccc[TMR_CCC_BSRC] ? cap_trig : sec_edge;
  wire logic fall = running & pre_fall;
  wire logic cap_a_do = fall & cap_a_req;
  wire logic cap_b_do = fall & cap_b_req;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_a_req <= 1'b0;
      cap_b_req <= 1'b0;
      cap_a_val <= TMR_CNT_ZERO;
      cap_b_val <= TMR_CNT_ZERO;
    end else begin
      if (cap_trig & ccc[TMR_CCC_CAPA]) begin
        cap_a_req <= 1'b1;
        cap_a_val <= counter_value;
      end else if (cap_a_do | ~running) begin
        cap_a_req <= 1'b0;
      end
      if (b_edge & ccc[TMR_CCC_CAPB]) begin
        cap_b_req <= 1'b1;
        cap_b_val <= counter_value;
      end else if (cap_b_do | ~running) begin
        cap_b_req <= 1'b0;
      end
    end
  end

  // Compare registers; capture wins over a write or read
  // Contents after stop carry no promise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_a <= TMR_CMP_RST;
      compare_b <= TMR_CMP_RST;
    end else begin
      if (cap_a_do)
        compare_a <= cap_a_val;
      else if (wr_cmpa)
        compare_a <= hwdata[15:0];
      if (cap_b_do)
        compare_b <= cap_b_val;
      else if (wr_cmpb)
        compare_b <= hwdata[15:0];
    end
  end

  // Match or capture signal on the next count clock rise
  logic cap_a_note;
  logic cap_b_note;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_a_note <= 1'b0;
      cap_b_note <= 1'b0;
      match_a_interrupt <= 1'b0;
      match_b_interrupt <= 1'b0;
    end else begin
      cap_a_note <= (cap_a_note | cap_a_do) & ~(pre_rise & cap_a_note) & running;
      cap_b_note <= (cap_b_note | cap_b_do) & ~(pre_rise & cap_b_note) & running;
      match_a_interrupt <= (hit_a & ~ccc[TMR_CCC_CAPA]) | (pre_rise & cap_a_note);
      match_b_interrupt <= (hit_b & ~ccc[TMR_CCC_CAPB]) | (pre_rise & cap_b_note);
    end
  end

  // Lower compare turns output on, higher turns it off
  wire logic b_first = (compare_b < compare_a);
  wire logic hit_on = b_first ? hit_b : hit_a;
  wire logic hit_off = b_first ? hit_a : hit_b;
  tmr_os_t os_state;
  tmr_os_t next_os_state;
  always_comb begin
    next_os_state = os_state;
    case (os_state)
      TMR_OS_IDLE: begin
        if (os_start)
          next_os_state = TMR_OS_WAIT;
      end
      TMR_OS_WAIT: begin
        if (!os_mode)
          next_os_state = TMR_OS_IDLE;
        else if (hit_on)
          next_os_state = TMR_OS_ACT;
      end
      TMR_OS_ACT: begin
        if (!os_mode || hit_off)
          next_os_state = TMR_OS_IDLE;
      end
      default: next_os_state = TMR_OS_IDLE;
    endcase
  end

  // Output inactive unless a pulse is running and output enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      os_state <= TMR_OS_IDLE;
      pulse_output_pin <= 1'b0;
    end else begin
      os_state <= next_os_state;
      pulse_output_pin <= outc[0] & (next_os_state == TMR_OS_ACT);
    end
  end

  // Control registers; software trigger bit is a strobe only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= TMR_STOP;
      ccc <= 3'h0;
      outc <= 2'h0;
      presc <= 8'h00;
    end else begin
      if (wr_mode)
        mode <= wmode;
      if (wr_ccc)
        ccc <= hwdata[2:0];
      if (wr_outc)
        outc <= {hwdata[TMR_OUTC_OSE], hwdata[TMR_OUTC_OE]};
      if (wr_presc)
        presc <= hwdata[7:0];
    end
  end

  // Read mux for address phase
  wire logic [31:0] rd_mux =
    (haddr == TMR_OFS_MODE) ? {28'h0, mode, 1'b0, overflow_flag} :
    (haddr == TMR_OFS_CCC) ? {29'h0, ccc} :
    (haddr == TMR_OFS_OUTC) ? {27'h0, outc[1], 3'h0, outc[0]} :
    (haddr == TMR_OFS_PRESC) ? {24'h0, presc} :
    (haddr == TMR_OFS_CMPA) ? {16'h0, compare_a} :
    (haddr == TMR_OFS_CMPB) ? {16'h0, compare_b} :
    (haddr == TMR_OFS_COUNT) ? {16'h0, counter_value} : 32'h0;

  // AHB address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph <= '0;
      aph_valid <= 1'b0;
      hrdata <= 32'h0;
    end else begin
      aph_valid <= bus_take;
      aph <= tmr_aph_t'{wr: hwrite, addr: haddr};
      if (bus_take & ~hwrite)
        hrdata <= rd_mux;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule
`default_nettype wire

/* File: logic/tmr_pkg.sv */
`default_nettype none
package tmr_pkg;
  // Register byte offsets
  localparam logic [7:0] TMR_OFS_MODE = 8'h00;
  localparam logic [7:0] TMR_OFS_CCC = 8'h04;
  localparam logic [7:0] TMR_OFS_OUTC = 8'h08;
  localparam logic [7:0] TMR_OFS_PRESC = 8'h0c;
  localparam logic [7:0] TMR_OFS_CMPA = 8'h10;
  localparam logic [7:0] TMR_OFS_CMPB = 8'h14;
  localparam logic [7:0] TMR_OFS_COUNT = 8'h18;
  // Field positions
  localparam int TMR_MODE_OVF = 0;
  localparam int TMR_MODE_LO = 2;
  localparam int TMR_CCC_CAPA = 0;
  localparam int TMR_CCC_CAPB = 1;
  localparam int TMR_CCC_BSRC = 2;
  localparam int TMR_OUTC_OE = 0;
  localparam int TMR_OUTC_OSE = 4;
  localparam int TMR_OUTC_SWT = 6;
  localparam int TMR_PRE_CLK = 0;
  localparam int TMR_PRE_ES = 4;
  localparam int TMR_PRE_ES2 = 6;
  // Reset values and constants
  localparam logic [15:0] TMR_CMP_RST = 16'h0000;
  localparam logic [15:0] TMR_CNT_MAX = 16'hffff;
  localparam logic [15:0] TMR_CNT_ONE = 16'h0001;
  localparam logic [15:0] TMR_CNT_ZERO = 16'h0000;
  localparam logic [3:0] TMR_DIV4 = 4'h3;
  localparam logic [3:0] TMR_DIV16 = 4'hf;
  localparam logic [3:0] TMR_DIV_ZERO = 4'h0;
  // Counting modes
  typedef enum logic [1:0] {
    TMR_STOP = 2'h0,
    TMR_FREE = 2'h1,
    TMR_EDGE_CLR = 2'h2,
    TMR_MATCH_CLR = 2'h3
  } tmr_mode_t;
  // Count clock sources
  typedef enum logic [1:0] {
    TMR_CK_FULL = 2'h0,
    TMR_CK_DIV4 = 2'h1,
    TMR_CK_DIV16 = 2'h2,
    TMR_CK_PIN = 2'h3
  } tmr_cksel_t;
  // One-shot pulse states
  typedef enum logic [2:0] {
    TMR_OS_IDLE = 3'b001,
    TMR_OS_WAIT = 3'b010,
    TMR_OS_ACT = 3'b100
  } tmr_os_t;
  // Latched AHB address phase
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
  } tmr_aph_t;
endpackage
`default_nettype wire

/* File: tb/tmr_oneshot_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module tmr_oneshot_sva
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Timer outputs
  input wire logic pulse_output_pin,
  input wire logic match_a_interrupt,
  input wire logic match_b_interrupt
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic mode_wr;
  logic stop_q;
  // Address phase decode
  wire logic rd_req = hsel && hready && htrans[1] && !hwrite;
  wire logic mode_req = hsel && hready && htrans[1] && hwrite && (haddr == TMR_OFS_MODE);
  // Track whether the stop code sits in the mode field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_wr <= 1'b0;
      stop_q <= 1'b1;
    end else begin
      mode_wr <= mode_req;
      if (mode_wr) begin
        stop_q <= (hwdata[3:2] == 2'h0);
      end
    end
  end
  AST_ZERO_WAIT: assert property (hreadyout == 1'b1 && hresp == 1'b0)
    else $error("bus slave stalled or answered error");
  AST_RDATA_HOLD: assert property (!rd_req |=> $stable(hrdata))
    else $error("read data moved without a read");
  AST_UNMAPPED: assert property (rd_req && haddr > TMR_OFS_COUNT |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_SWT_READ0: assert property (rd_req && haddr == TMR_OFS_OUTC |=> !hrdata[TMR_OUTC_SWT])
    else $error("software trigger bit reads one");
  AST_MATCHA_PULSE: assert property (match_a_interrupt |=> !match_a_interrupt)
    else $error("match a longer than one cycle");
  AST_MATCHB_PULSE: assert property (match_b_interrupt |=> !match_b_interrupt)
    else $error("match b longer than one cycle");
  AST_RISE_CAUSE: assert property ($rose(pulse_output_pin) |-> match_a_interrupt || match_b_interrupt)
    else $error("pulse rose without a compare match");
  AST_STOP_OUT: assert property (stop_q [*3] |-> !pulse_output_pin)
    else $error("pulse active while stopped");
  AST_STOP_QUIET: assert property (stop_q [*3] |-> !match_a_interrupt && !match_b_interrupt)
    else $error("match signal while stopped");
  // Main scenarios reached
  cover property ($rose(pulse_output_pin));
  cover property (match_a_interrupt);
  cover property (rd_req && haddr == TMR_OFS_OUTC);
endmodule
`default_nettype wire

/* File: tb/tmr_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
  // Clock and requested levels
  input wire logic hclk,
  input wire logic level_a,
  input wire logic level_b,
  // Load side
  input wire logic pulse_output_pin,
  output logic trigger_input_pin,
  output logic second_capture_pin,
  output logic [7:0] pulse_count
);
  logic prev;
  initial begin
    trigger_input_pin = 1'b0;
    second_capture_pin = 1'b0;
    pulse_count = 8'h0;
    prev = 1'b0;
  end
  // Trigger levels held steady between requests
  always @(posedge hclk) begin
    trigger_input_pin <= level_a;
    second_capture_pin <= level_b;
  end
  // Count pulses seen by the load
  always @(posedge hclk) begin
    prev <= pulse_output_pin;
    if (pulse_output_pin === 1'b1 && prev === 1'b0) begin
      pulse_count <= pulse_count + 8'h1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
bind tmr_oneshot tmr_oneshot_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pulse_output_pin(pulse_output_pin),
  .match_a_interrupt(match_a_interrupt), .match_b_interrupt(match_b_interrupt));
module tb
  import tmr_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} tmr_row_t;
  logic hclk, hresetn, hsel, hwrite, lvl, hreadyout, hresp, trig, cap, pulse, ma, mb;
  logic [7:0] haddr, npulse;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  int num_errors = 0;
  int n_compared = 0;
  tmr_row_t rows[8] = '{'{TMR_OFS_CMPA, 32'h1234, 32'h1234}, '{TMR_OFS_CMPB, 32'habcd, 32'habcd},
    '{TMR_OFS_PRESC, 32'hd5, 32'hd5}, '{TMR_OFS_CCC, 32'h5, 32'h5}, '{TMR_OFS_OUTC, 32'h51, 32'h11},
    '{8'h40, 32'hffffffff, 32'h0}, '{TMR_OFS_MODE, 32'h0, 32'h0}, '{TMR_OFS_COUNT, 32'h55, 32'h0}};
  logic [1:0] es[4] = '{2'h1, 2'h0, 2'h3, 2'h2};
  logic il[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic ex[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  tmr_oneshot dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .trigger_input_pin(trig), .second_capture_pin(cap),
    .pulse_output_pin(pulse), .match_a_interrupt(ma), .match_b_interrupt(mb));
  tmr_pin_model u_pins (.hclk(hclk), .level_a(lvl), .level_b(1'b0), .pulse_output_pin(pulse),
    .trigger_input_pin(trig), .second_capture_pin(cap), .pulse_count(npulse));
  task automatic finish_test();
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    if (hreadyout !== 1'b1) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    step_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    step_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic measure(output int w);
    int n;
    w = 0;
    n = 0;
    while (pulse !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    while (pulse === 1'b1 && w < 200) begin
      @(posedge hclk);
      w++;
    end
  endtask
  task automatic sw_pulse(input logic [15:0] a, input logic [15:0] b, input logic [31:0] exp);
    int w;
    wr(TMR_OFS_CMPA, {16'h0, a});
    wr(TMR_OFS_CMPB, {16'h0, b});
    wr(TMR_OFS_OUTC, 32'h51);
    measure(w);
    chk("sw_width", exp, 32'(w));
  endtask
  // Free-running clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    logic [31:0] q, q2;
    int w;
    {hresetn, hsel, hwrite, lvl, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("pulse_rst", 32'h0, {31'h0, pulse});
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, rows[i].a, rows[i].d, q);
      bus(1'b0, rows[i].a, 32'h0, q);
      chk("reg", rows[i].e, q);
    end
    wr(TMR_OFS_CCC, 32'h0);
    wr(TMR_OFS_PRESC, 32'h20);
    wr(TMR_OFS_OUTC, 32'h11);
    wr(TMR_OFS_MODE, 32'h4);
    // First tick lands one edge after the start write
    @(posedge hclk);
    bus(1'b0, TMR_OFS_COUNT, 32'h0, q);
    chk("count_run", 32'h1, {31'h0, q != 32'h0});
    sw_pulse(16'ha, 16'h5, 32'h5);
    sw_pulse(16'h4, 16'hc, 32'h8);
    bus(1'b0, TMR_OFS_COUNT, 32'h0, q);
    bus(1'b0, TMR_OFS_COUNT, 32'h0, q2);
    chk("count_after", 32'h1, {31'h0, q != q2});
    for (int i = 0; i < 4; i++) begin
      // Edge selection changed only while stopped
      wr(TMR_OFS_MODE, 32'h0);
      lvl <= il[i];
      wr(TMR_OFS_PRESC, {26'h0, es[i], 4'h0});
      wr(TMR_OFS_CMPA, 32'ha);
      wr(TMR_OFS_CMPB, 32'h5);
      wr(TMR_OFS_MODE, 32'h8);
      repeat (10) @(posedge hclk);
      lvl <= ~il[i];
      measure(w);
      chk("edge_width", ex[i] ? 32'h5 : 32'h0, 32'(w));
    end
    wr(TMR_OFS_MODE, 32'h0);
    wr(TMR_OFS_PRESC, 32'h10);
    lvl <= 1'b0;
    repeat (10) @(posedge hclk);
    lvl <= 1'b1;
    wr(TMR_OFS_OUTC, 32'h51);
    measure(w);
    chk("stopped_pulse", 32'h0, 32'(w));
    wr(TMR_OFS_MODE, 32'hc);
    wr(TMR_OFS_OUTC, 32'h51);
    measure(w);
    chk("matchclr_pulse", 32'h0, 32'(w));
    chk("pulse_count", 32'h5, {24'h0, npulse});
    wr(TMR_OFS_MODE, 32'h0);
    wr(TMR_OFS_PRESC, 32'h20);
    wr(TMR_OFS_MODE, 32'h4);
    // Wrap falls 65536 edges after the start; the clear lands one edge later
    repeat (65535) @(posedge hclk);
    wr(TMR_OFS_MODE, 32'h4);
    bus(1'b0, TMR_OFS_MODE, 32'h0, q);
    chk("ovf_set", 32'h1, {31'h0, q[TMR_MODE_OVF]});
    wr(TMR_OFS_MODE, 32'h4);
    bus(1'b0, TMR_OFS_MODE, 32'h0, q);
    chk("ovf_clr", 32'h0, {31'h0, q[TMR_MODE_OVF]});
    // Capture into compare_a on a trigger edge, one-shot off
    wr(TMR_OFS_OUTC, 32'h1);
    wr(TMR_OFS_MODE, 32'h0);
    lvl <= 1'b0;
    wr(TMR_OFS_CCC, 32'h1);
    wr(TMR_OFS_PRESC, 32'h10);
    wr(TMR_OFS_MODE, 32'h4);
    repeat (20) @(posedge hclk);
    lvl <= 1'b1;
    w = 0;
    while (ma !== 1'b1 && w < 100) begin
      @(posedge hclk);
      w++;
    end
    chk("cap_irq", 32'h1, {31'h0, ma});
    bus(1'b0, TMR_OFS_CMPA, 32'h0, q);
    chk("cap_val", 32'h1, {31'h0, q != 32'ha});
    // Pin as count clock, same edge selection, captures nothing
    wr(TMR_OFS_PRESC, 32'h13);
    lvl <= 1'b0;
    repeat (10) @(posedge hclk);
    lvl <= 1'b1;
    repeat (10) @(posedge hclk);
    bus(1'b0, TMR_OFS_CMPA, 32'h0, q2);
    chk("pin_clk_cap", q, q2);
    finish_test();
  end
endmodule
`default_nettype wire
